// ---- pkg/spdp_regs.svh ----
/*
 * Named constants of the serial program download port: instruction codes,
 * memory geometry, erased values and wait times.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef SPDP_REGS_SVH
`define SPDP_REGS_SVH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define SPDP_OP_ENABLE1 8'hac
`define SPDP_OP_ENABLE2 8'h53
`define SPDP_OP_ERASE2 8'h80
`define SPDP_OP_POLL 8'hf0
`define SPDP_OP_LOAD_EXT 8'h4d
`define SPDP_OP_LOAD_HI 8'h48
`define SPDP_OP_LOAD_LO 8'h40
`define SPDP_OP_READ_HI 8'h28
`define SPDP_OP_READ_LO 8'h20
`define SPDP_OP_READ_EE 8'ha0
`define SPDP_OP_WRITE_PAGE 8'h4c
`define SPDP_OP_WRITE_EE 8'hc0

// ----------------------------------------------------------------------
// Geometry and erased values
// ----------------------------------------------------------------------
`define SPDP_FLASH_AW 17
`define SPDP_FLASH_DEPTH 131072
`define SPDP_EE_AW 12
`define SPDP_EE_DEPTH 4096
`define SPDP_PAGE_AW 7
`define SPDP_PAGE_DEPTH 128
`define SPDP_PAGE_LAST 7'h7f
`define SPDP_FLASH_LAST 17'h1ffff
`define SPDP_ERASED_BYTE 8'hff
`define SPDP_ERASED_WORD 16'hffff
`define SPDP_LAST_BIT 3'h7
`define SPDP_SLOT_THREE 2'h2
`define SPDP_LAST_SLOT 2'h3
`define SPDP_SYNC_RST 2'h2

// ----------------------------------------------------------------------
// Timing: wait times in microseconds, clock period in nanoseconds
// ----------------------------------------------------------------------
`define SPDP_SYS_CLK_NS 10
`define SPDP_FLASH_WAIT_US 4500
`define SPDP_EE_WAIT_US 3600
`define SPDP_ERASE_WAIT_US 9000
`define SPDP_US_TO_CYC(us) ((us) * 1000 / `SPDP_SYS_CLK_NS)
`define SPDP_WAIT_W 20

`endif

// ---- pkg/spdp_pkg.sv ----
/*
 * Types shared by the serial program download port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spdp_pkg;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef logic [7:0] spdp_byte_t;

	// Self-timed memory operation sequencer, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_PAGE = 6'b000010,
		ST_ERASE = 6'b000100,
		ST_EE_CLR = 6'b001000,
		ST_EE_WR = 6'b010000,
		ST_SETTLE = 6'b100000
	} spdp_state_t;

endpackage

// ---- core/spdp_link.sv ----
/*
 * Link-side capture of the serial data input, clocked by the serial clock.
 * Assumes the system side reads the captured bit only after it has seen
 * the matching rising serial clock edge through its own synchroniser.
 */
`timescale 1ns/1ps
module spdp_link (
	input wire logic serial_clk,
	input wire logic serial_prog_data_in,
	output logic link_bit_q
);
	import spdp_pkg::*;

	logic link_bit_d;

	// Data bit is held stable for a whole serial clock period
	always_comb begin
		link_bit_d = serial_prog_data_in;
	end

	always_ff @(posedge serial_clk) begin
		link_bit_q <= link_bit_d;
	end

endmodule

// ---- core/spdp_sync.sv ----
/*
 * Two-flop level synchroniser for the reset pin and serial clock level.
 * Assumes a synchronous active-low reset on the system clock.
 */
`timescale 1ns/1ps
`include "spdp_regs.svh"
module spdp_sync (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [1:0] async_in,
	output logic [1:0] sync_q
);
	import spdp_pkg::*;

	logic [1:0] meta_q;
	logic [1:0] meta_d;
	logic [1:0] sync_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_q <= `SPDP_SYNC_RST;
			sync_q <= `SPDP_SYNC_RST;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

endmodule

// ---- core/spdp_port.sv ----
/*
 * Serial program download port: four-byte instruction engine, page buffer,
 * flash and EEPROM arrays with self-timed write, erase and busy polling.
 * Assumes a 100 MHz sys_clk, a serial clock whose phases each span at
 * least three system cycles, and a programmer keeping its own waits.
 */
`timescale 1ns/1ps
`include "spdp_regs.svh"
module spdp_port #(
	parameter logic [`SPDP_WAIT_W-1:0] FLASH_WAIT_CYC =
		`SPDP_WAIT_W'(`SPDP_US_TO_CYC(`SPDP_FLASH_WAIT_US)),
	parameter logic [`SPDP_WAIT_W-1:0] EE_WAIT_CYC =
		`SPDP_WAIT_W'(`SPDP_US_TO_CYC(`SPDP_EE_WAIT_US)),
	parameter logic [`SPDP_WAIT_W-1:0] ERASE_WAIT_CYC =
		`SPDP_WAIT_W'(`SPDP_US_TO_CYC(`SPDP_ERASE_WAIT_US))
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic serial_clk,
	input wire logic serial_prog_data_in,
	input wire logic ext_reset_n,
	output logic serial_prog_data_out,
	output logic operation_pending_flag,
	output logic cpu_run
);
	import spdp_pkg::*;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [15:0] flash_mem [0:`SPDP_FLASH_DEPTH-1];
	logic [7:0] ee_mem [0:`SPDP_EE_DEPTH-1];
	logic [15:0] page_buf [0:`SPDP_PAGE_DEPTH-1];

	// ------------------------------------------------------------------
	// Front end signals
	// ------------------------------------------------------------------
	logic [1:0] sync_lvl;
	logic ext_hi;
	logic sck_s;
	logic link_bit;
	logic sck_prev_q, sck_prev_d;
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic [1:0] slot_q, slot_d;
	spdp_byte_t shin_q, shin_d;
	spdp_byte_t b1_q, b1_d, b2_q, b2_d, b3_q, b3_d;
	spdp_byte_t out_sh_q, out_sh_d;
	logic dout_q, dout_d;
	logic prog_en_q, prog_en_d;
	spdp_byte_t ext_addr_q, ext_addr_d;
	logic run_q, run_d;
	logic rise_ev, fall_ev, byte_end, instr_done;
	spdp_byte_t nb, slot4_resp;

	// ------------------------------------------------------------------
	// Sequencer signals
	// ------------------------------------------------------------------
	spdp_state_t state_q, state_d;
	logic [`SPDP_FLASH_AW-1:0] walk_q, walk_d;
	logic [`SPDP_WAIT_W-1:0] wait_q, wait_d;
	logic [`SPDP_FLASH_AW-`SPDP_PAGE_AW-1:0] page_q, page_d;
	logic [`SPDP_EE_AW-1:0] ee_addr_q, ee_addr_d;
	spdp_byte_t ee_data_q, ee_data_d;
	logic pend_q, pend_d;
	logic fl_we, ee_we, pb_we, pb_hi, pb_clr;
	logic [`SPDP_FLASH_AW-1:0] fl_wa;
	logic [15:0] fl_wd;
	logic [`SPDP_EE_AW-1:0] ee_wa;
	spdp_byte_t ee_wd;
	logic [`SPDP_PAGE_AW-1:0] pb_wa;

	// Instruction opcode check, only valid once programming is enabled
	function automatic logic cmd_is(input spdp_byte_t op);
		return prog_en_q && (b1_q == op);
	endfunction

	// ------------------------------------------------------------------
	// Clock crossing
	// ------------------------------------------------------------------
	// pin levels synchronised
	spdp_sync u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({ext_reset_n, serial_clk}),
		.sync_q(sync_lvl)
	);

	// Bit captured on the serial clock, read after its edge is seen here
	spdp_link u_link (
		.serial_clk(serial_clk),
		.serial_prog_data_in(serial_prog_data_in),
		.link_bit_q(link_bit)
	);

	// Edge detect on the synchronised level only
	always_comb begin
		ext_hi = sync_lvl[1];
		sck_s = sync_lvl[0];
		sck_prev_d = sck_s;
		rise_ev = sck_s && !sck_prev_q;
		fall_ev = !sck_s && sck_prev_q;
		byte_end = rise_ev && (bit_cnt_q == `SPDP_LAST_BIT);
		instr_done = byte_end && (slot_q == `SPDP_LAST_SLOT);
		nb = {shin_q[6:0], link_bit};
	end

	// ------------------------------------------------------------------
	// Answer for the fourth byte slot
	// ------------------------------------------------------------------
	// read data, flash via stored extended byte
	always_comb begin
		slot4_resp = nb;
		if (cmd_is(`SPDP_OP_READ_LO)) begin
			slot4_resp = flash_mem[{ext_addr_q[0], b2_q, nb}][7:0];
		end else if (cmd_is(`SPDP_OP_READ_HI)) begin
			slot4_resp = flash_mem[{ext_addr_q[0], b2_q, nb}][15:8];
		end else if (cmd_is(`SPDP_OP_READ_EE)) begin
			slot4_resp = ee_mem[{b2_q[3:0], nb}];
		end else if (cmd_is(`SPDP_OP_POLL)) begin
			slot4_resp = {7'h00, pend_q};
		end
	end

	// ------------------------------------------------------------------
	// Shift engine and session state
	// ------------------------------------------------------------------
	always_comb begin
		bit_cnt_d = bit_cnt_q;
		slot_d = slot_q;
		shin_d = shin_q;
		b1_d = b1_q;
		b2_d = b2_q;
		b3_d = b3_q;
		out_sh_d = out_sh_q;
		dout_d = dout_q;
		prog_en_d = prog_en_q;
		ext_addr_d = ext_addr_q;
		run_d = ext_hi;
		if (ext_hi) begin
			bit_cnt_d = 3'h0;
			slot_d = 2'h0;
			out_sh_d = 8'h00;
			dout_d = 1'b0;
			prog_en_d = 1'b0;
		end else begin
			if (rise_ev) begin
				shin_d = nb;
				bit_cnt_d = 3'(bit_cnt_q + 3'h1);
			end
			if (byte_end) begin
				slot_d = 2'(slot_q + 2'h1);
				case (slot_q)
					2'h0: b1_d = nb;
					2'h1: b2_d = nb;
					2'h2: b3_d = nb;
					default: b3_d = b3_q;
				endcase
				// next slot echoes the byte just received; after the third byte it carries slot4_resp
				out_sh_d = (slot_q == `SPDP_SLOT_THREE) ? slot4_resp : nb;
			end
			// enable once the fourth byte is in, on matching first and second bytes only
			if (instr_done && b1_q == `SPDP_OP_ENABLE1 &&
				b2_q == `SPDP_OP_ENABLE2) begin
				prog_en_d = 1'b1;
			end
			if (instr_done && cmd_is(`SPDP_OP_LOAD_EXT)) begin
				ext_addr_d = b3_q;
			end
			if (fall_ev) begin
				dout_d = out_sh_q[7];
				out_sh_d = {out_sh_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sck_prev_q <= 1'b0;
			bit_cnt_q <= 3'h0;
			slot_q <= 2'h0;
			shin_q <= 8'h00;
			b1_q <= 8'h00;
			b2_q <= 8'h00;
			b3_q <= 8'h00;
			out_sh_q <= 8'h00;
			dout_q <= 1'b0;
			prog_en_q <= 1'b0;
			ext_addr_q <= 8'h00;
			run_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_prev_d;
			bit_cnt_q <= bit_cnt_d;
			slot_q <= slot_d;
			shin_q <= shin_d;
			b1_q <= b1_d;
			b2_q <= b2_d;
			b3_q <= b3_d;
			out_sh_q <= out_sh_d;
			dout_q <= dout_d;
			prog_en_q <= prog_en_d;
			ext_addr_q <= ext_addr_d;
			run_q <= run_d;
		end
	end

	// ------------------------------------------------------------------
	// Self-timed sequencer
	// ------------------------------------------------------------------
	// Writes, erase and page loads are dropped while busy, since touching memory mid-write corrupts it; reads, poll and extended loads still act
	always_comb begin
		state_d = state_q;
		walk_d = walk_q;
		wait_d = (wait_q != '0) ? `SPDP_WAIT_W'(wait_q - 1'b1) : wait_q;
		page_d = page_q;
		ee_addr_d = ee_addr_q;
		ee_data_d = ee_data_q;
		fl_we = 1'b0;
		fl_wa = walk_q;
		fl_wd = `SPDP_ERASED_WORD;
		ee_we = 1'b0;
		ee_wa = ee_addr_q;
		ee_wd = `SPDP_ERASED_BYTE;
		pb_clr = 1'b0;
		// one byte per load with 7-bit word address
		pb_we = instr_done && !ext_hi && state_q == ST_IDLE &&
			(cmd_is(`SPDP_OP_LOAD_LO) || cmd_is(`SPDP_OP_LOAD_HI));
		pb_hi = cmd_is(`SPDP_OP_LOAD_HI);
		pb_wa = b3_q[`SPDP_PAGE_AW-1:0];
		case (state_q)
			ST_IDLE: begin
				// act only after the fourth byte
				if (instr_done && !ext_hi) begin
					if (cmd_is(`SPDP_OP_ENABLE1) &&
						b2_q == `SPDP_OP_ERASE2) begin
						state_d = ST_ERASE;
						walk_d = '0;
						wait_d = ERASE_WAIT_CYC;
					end else if (cmd_is(`SPDP_OP_WRITE_PAGE)) begin
						// page from extended, 15:8 and top of LSB
						page_d = {ext_addr_q[0], b2_q, b3_q[7]};
						state_d = ST_PAGE;
						walk_d = '0;
						wait_d = FLASH_WAIT_CYC;
					end else if (cmd_is(`SPDP_OP_WRITE_EE)) begin
						// address and data in one instruction
						ee_addr_d = {b2_q[3:0], b3_q};
						ee_data_d = nb;
						state_d = ST_EE_CLR;
						wait_d = EE_WAIT_CYC;
					end
				end
			end
			ST_PAGE: begin
				fl_we = 1'b1;
				fl_wa = {page_q, walk_q[`SPDP_PAGE_AW-1:0]};
				fl_wd = page_buf[walk_q[`SPDP_PAGE_AW-1:0]];
				pb_clr = 1'b1;
				walk_d = `SPDP_FLASH_AW'(walk_q + 1'b1);
				if (walk_q[`SPDP_PAGE_AW-1:0] == `SPDP_PAGE_LAST) begin
					state_d = ST_SETTLE;
				end
			end
			ST_ERASE: begin
				// both arrays walked to all ones
				fl_we = 1'b1;
				ee_we = (walk_q[`SPDP_FLASH_AW-1:`SPDP_EE_AW] == '0);
				ee_wa = walk_q[`SPDP_EE_AW-1:0];
				walk_d = `SPDP_FLASH_AW'(walk_q + 1'b1);
				if (walk_q == `SPDP_FLASH_LAST) begin
					state_d = ST_SETTLE;
				end
			end
			ST_EE_CLR: begin
				ee_we = 1'b1;
				state_d = ST_EE_WR;
			end
			ST_EE_WR: begin
				ee_we = 1'b1;
				ee_wd = ee_data_q;
				state_d = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (wait_q == '0) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		pend_d = (state_d != ST_IDLE);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			walk_q <= '0;
			wait_q <= '0;
			page_q <= '0;
			ee_addr_q <= '0;
			ee_data_q <= 8'h00;
			pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			walk_q <= walk_d;
			wait_q <= wait_d;
			page_q <= page_d;
			ee_addr_q <= ee_addr_d;
			ee_data_q <= ee_data_d;
			pend_q <= pend_d;
		end
	end

	// Arrays carry no reset; writes come only from the logic above
	always_ff @(posedge sys_clk) begin
		if (fl_we) begin
			flash_mem[fl_wa] <= fl_wd;
		end
		if (ee_we) begin
			ee_mem[ee_wa] <= ee_wd;
		end
		if (pb_we && pb_hi) begin
			page_buf[pb_wa][15:8] <= nb;
		end else if (pb_we) begin
			page_buf[pb_wa][7:0] <= nb;
		end
		if (pb_clr) begin
			page_buf[walk_q[`SPDP_PAGE_AW-1:0]] <= `SPDP_ERASED_WORD;
		end
	end

	// Outputs straight from flops
	always_comb begin
		serial_prog_data_out = dout_q;
		operation_pending_flag = pend_q;
		cpu_run = run_q;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_ee_clear;
		state_q == ST_EE_CLR && ee_we && ee_wd == `SPDP_ERASED_BYTE;
	endsequence
	sequence s_ee_store;
		state_q == ST_EE_WR && ee_we && ee_wd == ee_data_q;
	endsequence

	chk_enable_gate: assert property (
		$rose(pend_q) |-> $past(prog_en_q))
		else $error("operation started without programming enable");
	chk_four_bytes: assert property (
		$rose(pend_q) |-> $past(instr_done))
		else $error("operation started before fourth byte");
	chk_ee_erase_first: assert property (
		$rose(state_q == ST_EE_CLR) |-> s_ee_clear ##1 s_ee_store)
		else $error("eeprom store not preceded by erase");
	chk_erase_ones: assert property (
		state_q == ST_ERASE |-> fl_we && fl_wd == `SPDP_ERASED_WORD)
		else $error("chip erase wrote a non-erased word");
	chk_in_rise: assert property (
		rise_ev && !ext_hi |=> shin_q == {$past(shin_q[6:0]),
			$past(link_bit)})
		else $error("input bit not shifted on rising edge");
	chk_out_fall: assert property (
		!fall_ev && !ext_hi |=> $stable(dout_q))
		else $error("output changed without falling edge");
	chk_enable_echo: assert property (
		byte_end && slot_q == 2'h1 && !ext_hi |=> out_sh_q == $past(nb))
		else $error("second byte not echoed in third slot");
	chk_ext_keep: assert property (
		!(instr_done && cmd_is(`SPDP_OP_LOAD_EXT)) |=> $stable(ext_addr_q))
		else $error("extended address changed without load");
	chk_session_end: assert property (
		ext_hi |=> !prog_en_q && run_q)
		else $error("programming mode kept with reset pin high");
	chk_poll_bit: assert property (
		byte_end && slot_q == `SPDP_SLOT_THREE && !ext_hi &&
		cmd_is(`SPDP_OP_POLL) |=> out_sh_q == {7'h00, $past(pend_q)})
		else $error("poll answer does not show pending bit");

endmodule

// ---- test/spdp_prog_model.sv ----
/*
 * Programmer model: serial master that drives the download port's clock,
 * data input and reset pin, and samples the data output.
 * Assumes the bench calls one task at a time; the timescale is in ns.
 */
`timescale 1ns/1ps
module spdp_prog_model #(
	parameter int HALF_NS = 32,
	// Shortened power-up wait so the run stays brief
	parameter int POWER_WAIT_NS = 2000
) (
	output logic serial_clk,
	output logic serial_prog_data_in,
	output logic ext_reset_n,
	input wire logic serial_prog_data_out
);
	// reset and clock low at power up
	initial begin
		serial_clk = 1'b0;
		serial_prog_data_in = 1'b0;
		ext_reset_n = 1'b0;
	end

	// MSB first, four bytes, 32 ns phases
	task automatic send(input logic [31:0] ins, output logic [31:0] rsp);
		for (int i = 31; i >= 0; i--) begin
			serial_prog_data_in = ins[i];
			#HALF_NS serial_clk = 1'b1;
			rsp[i] = serial_prog_data_out;
			#HALF_NS serial_clk = 1'b0;
		end
		// Released line shows the inverse, never a stale bit
		serial_prog_data_in = ~ins[0];
		// Let the released level stand before the next frame drives it
		#HALF_NS;
	endtask

	// Session end: device leaves programming mode
	task automatic pin_high();
		ext_reset_n = 1'b1;
		#100;
	endtask

	// wait before enable after reset goes low
	task automatic pin_low();
		ext_reset_n = 1'b0;
		#POWER_WAIT_NS;
	endtask

	// all four bytes sent, retry after a bad echo
	task automatic enable(output logic [7:0] echo);
		logic [31:0] r;
		send(32'hac530000, r);
		echo = r[15:8];
		if (echo !== 8'h53) begin
			pin_high();
			pin_low();
			send(32'hac530000, r);
		end
	endtask
endmodule

// ---- test/test_serial_program_download_port.sv ----
/*
 * Self-checking bench of the serial program download port.
 * Assumes the programmer model in its own file and short busy times.
 */
`timescale 1ns/1ps
module test_serial_program_download_port;
	logic sys_clk, rst_n, serial_clk, serial_prog_data_in, ext_reset_n;
	logic serial_prog_data_out, operation_pending_flag, cpu_run;
	int num_errors = 0;
	int checks = 0;
	logic [31:0] r;
	logic [7:0] e;

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
	end end

	// ------------------------------------------------------------------
	// Clock, design and programmer
	// ------------------------------------------------------------------
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	// Busy times long enough for a poll to land while pending
	spdp_port #(
		.FLASH_WAIT_CYC(20'd600),
		.EE_WAIT_CYC(20'd600),
		.ERASE_WAIT_CYC(20'd50)
	) u_dut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.serial_clk(serial_clk),
		.serial_prog_data_in(serial_prog_data_in),
		.ext_reset_n(ext_reset_n),
		.serial_prog_data_out(serial_prog_data_out),
		.operation_pending_flag(operation_pending_flag),
		.cpu_run(cpu_run)
	);

	spdp_prog_model u_prog (
		.serial_clk(serial_clk),
		.serial_prog_data_in(serial_prog_data_in),
		.ext_reset_n(ext_reset_n),
		.serial_prog_data_out(serial_prog_data_out)
	);

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (operation_pending_flag !== 1'b0 && n < 5000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 5000) begin
			num_errors++;
			$display("CHECK FAILED idle exp 0 got 1");
			end_sim();
		end
	endtask

	task automatic ee_wr(input logic [11:0] a, input logic [7:0] d);
		u_prog.send({8'hc0, 4'h0, a, d}, r);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_session();
		u_prog.pin_high();
		`CHK("cpu_run high", 1'b1, cpu_run)
		`CHK("dout idle", 1'b0, serial_prog_data_out)
		u_prog.pin_low();
		`CHK("cpu_run low", 1'b0, cpu_run)
		u_prog.enable(e);
		`CHK("enable echo", 8'h53, e)
		$display("t_session done");
	endtask

	task automatic t_eeprom();
		ee_wr(12'h00a, 8'ha5);
		`CHK("ee pending", 1'b1, operation_pending_flag)
		// Second write lands while busy and is dropped
		ee_wr(12'h00a, 8'h77);
		u_prog.send(32'hf0000000, r);
		`CHK("poll busy", 8'h01, r[7:0])
		wait_idle();
		u_prog.send(32'hf0000000, r);
		`CHK("poll idle", 8'h00, r[7:0])
		u_prog.send(32'ha0000a00, r);
		`CHK("ee first", 8'ha5, r[7:0])
		ee_wr(12'h00a, 8'h5a);
		wait_idle();
		u_prog.send(32'ha0000a00, r);
		`CHK("ee rewrite", 8'h5a, r[7:0])
		$display("t_eeprom done");
	endtask

	task automatic t_refuse();
		u_prog.pin_high();
		u_prog.pin_low();
		// Write without enable must be ignored
		ee_wr(12'h00a, 8'h11);
		`CHK("no pending", 1'b0, operation_pending_flag)
		u_prog.enable(e);
		u_prog.send(32'ha0000a00, r);
		`CHK("ee kept", 8'h5a, r[7:0])
		$display("t_refuse done");
	endtask

	task automatic t_flash();
		logic [31:0] ins [8];
		logic [7:0] ex [4];
		ins = '{32'h4d000100, 32'h40000034, 32'h48000012, 32'h40007fcd,
			32'h48007fab, 32'h20238000, 32'h28238000, 32'h2023ff00};
		ex = '{8'h34, 8'h12, 8'hcd, 8'hab};
		// extended byte, then low before high lane
		for (int i = 0; i < 5; i++)
			u_prog.send(ins[i], r);
		u_prog.send(32'h4c238000, r);
		`CHK("page pending", 1'b1, operation_pending_flag)
		wait_idle();
		for (int i = 0; i < 3; i++) begin
			u_prog.send(ins[i + 5], r);
			`CHK("flash read", ex[i], r[7:0])
		end
		u_prog.send(32'h2823ff00, r);
		`CHK("flash last", ex[3], r[7:0])
		// Pin pulse keeps the extended byte
		u_prog.pin_high();
		u_prog.pin_low();
		u_prog.enable(e);
		u_prog.send(ins[5], r);
		`CHK("ext kept", ex[0], r[7:0])
		$display("t_flash done");
	endtask

	// Erase walk outlasts the run; only locations already walked are read
	task automatic t_erase();
		u_prog.send(32'hac800000, r);
		`CHK("erase pending", 1'b1, operation_pending_flag)
		u_prog.send(32'hf0000000, r);
		`CHK("erase poll", 8'h01, r[7:0])
		u_prog.send(32'ha0000a00, r);
		`CHK("ee erased", 8'hff, r[7:0])
		u_prog.send(32'h4d000000, r);
		u_prog.send(32'h20000000, r);
		`CHK("flash erased lo", 8'hff, r[7:0])
		u_prog.send(32'h28000000, r);
		`CHK("flash erased hi", 8'hff, r[7:0])
		$display("t_erase done");
	endtask

	// ------------------------------------------------------------------
	// Main sequence and hang guard
	// ------------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (5) @(negedge sys_clk);
		t_session();
		t_eeprom();
		t_refuse();
		t_flash();
		t_erase();
		end_sim();
	end

	initial begin
		#900000;
		num_errors++;
		$display("CHECK FAILED run time exp done got hang");
		end_sim();
	end
endmodule
